// ===== rtl/pvp_top.v
`timescale 1ns/1ns
`include "pvp_regs.vh"

module pvp_top #(
  parameter [23:0] MAKER_OUI  = 24'h123456, // value is arbitrary
  parameter [23:0] PART_IDENT = 24'hABCDEF  // value is arbitrary
) (
  // clock and reset
  input  wire        CLOCK_IN,
  input  wire        RESETN_IN,
  // register port
  input  wire [3:0]  ADDR_IN,
  input  wire [7:0]  WDATA_IN,
  input  wire        WR_IN,
  input  wire        RD_IN,
  output reg  [7:0]  RDATA_OUT,
  // power class straps
  input  wire [2:0]  POWER_CLASS_STRAPS_IN,
  // received packet report
  input  wire        PKT_DONE_IN,
  input  wire [15:0] PKT_BITS_IN,
  input  wire        ARB_ACCEL_IN,
  // arbitration requests
  input  wire        FAIR_REQ_SET_IN,
  input  wire        PRIO_REQ_SET_IN,
  output reg         FAIR_REQ_OUT,
  output reg         PRIO_REQ_OUT,
  // self-id fields and port control
  output reg  [1:0]  SELF_ID_RATE_FIELD_OUT,
  output reg  [1:0]  PEER_SPEED_ADV_OUT,
  output reg  [2:0]  SELF_ID_PWR_OUT,
  output reg  [1:0]  PORT_DISABLE_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [2:0]  page_r;
  reg  [3:0]  port_sel_r;
  reg         hold_r;
  reg  [1:0]  speed_r;
  reg  [2:0]  pwr_r;
  reg         pwr_loaded_r;
  reg  [1:0]  dis_r;
  reg  [2:0]  strap_s1_r;
  reg  [2:0]  strap_s2_r;
  reg  [1:0]  strap_age_r;   // edges since reset, saturates at 2
  reg  [7:0]  rd_nxt;
  reg         clr_nxt;

  wire on_ident  = (page_r == `PVP_PAGE_IDENT);
  wire on_vendor = (page_r == `PVP_PAGE_VENDOR);
  wire on_port   = (page_r == `PVP_PAGE_PORT);
  wire paged     = ADDR_IN[3];

  // pick byte of a 24-bit identifier, msb first from base offset
  function [7:0] pvp_id_byte;
    input [23:0] val;
    input [1:0]  idx;
    begin
      case (idx)
        2'h0:    pvp_id_byte = val[23:16];
        2'h1:    pvp_id_byte = val[15:8];
        default: pvp_id_byte = val[7:0];
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // strap synchroniser; straps are pins, so two flops first
  // ----------------------------------------------------------------
  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      strap_s1_r  <= 3'h0;
      strap_s2_r  <= 3'h0;
      strap_age_r <= 2'h0;
    end else begin
      strap_s1_r <= POWER_CLASS_STRAPS_IN;
      strap_s2_r <= strap_s1_r;
      // second flop holds real pin value only after two edges
      if (strap_age_r != 2'h2)
        strap_age_r <= strap_age_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // register writes; only hardware reset touches these fields
  // ----------------------------------------------------------------
  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      page_r       <= `PVP_PAGE_PORT;
      port_sel_r   <= 4'h0;
      hold_r       <= `PVP_HOLD_RST;
      speed_r      <= `PVP_SPEED_RST;
      pwr_r        <= 3'h0;
      pwr_loaded_r <= 1'b0;
      dis_r        <= 2'h0;
    end else begin
      // strap value taken once, after the synchroniser settles
      if (!pwr_loaded_r && strap_age_r == 2'h2) begin
        pwr_r        <= strap_s2_r;
        pwr_loaded_r <= 1'b1;
      end
      if (WR_IN) begin
        if (ADDR_IN == `PVP_BASE_PAGE_REG) begin
          page_r     <= WDATA_IN[`PVP_PAGE_SEL_HI:`PVP_PAGE_SEL_LO];
          port_sel_r <= WDATA_IN[`PVP_PORT_SEL_HI:`PVP_PORT_SEL_LO];
        end
        // software write wins over strap; reserved code 101 kept as written
        if (ADDR_IN == `PVP_BASE_PWR_REG) begin
          pwr_r        <= WDATA_IN[`PVP_PWR_HI:`PVP_PWR_LO];
          pwr_loaded_r <= 1'b1;
        end
        if (paged && on_vendor && ADDR_IN == `PVP_OFS_VENDOR_CTRL) begin
          hold_r <= WDATA_IN[`PVP_HOLD_BIT];
          // illegal code 11 is dropped, old speed stays
          if (WDATA_IN[`PVP_SPEED_HI:`PVP_SPEED_LO] != `PVP_SPEED_ILLEGAL)
            speed_r <= WDATA_IN[`PVP_SPEED_HI:`PVP_SPEED_LO];
        end
        if (paged && on_port && ADDR_IN == `PVP_OFS_PORT_CTRL &&
            port_sel_r < `PVP_PORTS) begin
          dis_r[port_sel_r[0]] <= WDATA_IN[`PVP_DIS_BIT];
        end
        // identification and test locations ignore writes
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode; reserved and test locations read zero
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt = 8'h00;
    if (!paged) begin
      case (ADDR_IN)
        `PVP_BASE_PWR_REG:  rd_nxt = {5'h00, pwr_r};
        `PVP_BASE_PAGE_REG: rd_nxt = {page_r, 1'b0, port_sel_r};
        default:            rd_nxt = 8'h00;
      endcase
    end else if (on_ident) begin
      case (ADDR_IN)
        `PVP_OFS_COMPLIANCE: rd_nxt = `PVP_COMPLIANCE_VAL;
        `PVP_OFS_OUI_HI,
        `PVP_OFS_OUI_MID,
        `PVP_OFS_OUI_LO:     rd_nxt = pvp_id_byte(MAKER_OUI, ADDR_IN[1:0] - 2'h2);
        `PVP_OFS_PART_HI,
        `PVP_OFS_PART_MID,
        `PVP_OFS_PART_LO:    rd_nxt = pvp_id_byte(PART_IDENT, ADDR_IN[1:0] - 2'h1);
        default:             rd_nxt = 8'h00;
      endcase
    end else if (on_vendor) begin
      if (ADDR_IN == `PVP_OFS_VENDOR_CTRL)
        rd_nxt = {hold_r, 5'h00, speed_r};
    end else if (on_port) begin
      if (ADDR_IN == `PVP_OFS_PORT_CTRL && port_sel_r < `PVP_PORTS)
        rd_nxt = {7'h00, dis_r[port_sel_r[0]]};
    end
  end

  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN)
      RDATA_OUT <= rd_nxt;
    else
      RDATA_OUT <= 8'h00; // data valid only the cycle after the strobe
  end

  // ----------------------------------------------------------------
  // request clearing on received packets
  // ----------------------------------------------------------------
  always @* begin
    clr_nxt = 1'b0;
    if (PKT_DONE_IN) begin
      if (hold_r && ARB_ACCEL_IN)
        clr_nxt = (PKT_BITS_IN > `PVP_ACK_BITS);
      else
        clr_nxt = (PKT_BITS_IN != `PVP_ACK_BITS);
    end
  end

  // a new request in the clearing cycle survives
  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      FAIR_REQ_OUT <= 1'b0;
      PRIO_REQ_OUT <= 1'b0;
    end else begin
      FAIR_REQ_OUT <= FAIR_REQ_SET_IN | (FAIR_REQ_OUT & ~clr_nxt);
      PRIO_REQ_OUT <= PRIO_REQ_SET_IN | (PRIO_REQ_OUT & ~clr_nxt);
    end
  end

  // ----------------------------------------------------------------
  // self-id fields, registered copies
  // ----------------------------------------------------------------
  always @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SELF_ID_RATE_FIELD_OUT <= `PVP_SPEED_RST;
      PEER_SPEED_ADV_OUT     <= `PVP_SPEED_S400;
      SELF_ID_PWR_OUT        <= 3'h0;
      PORT_DISABLE_OUT       <= 2'h0;
    end else begin
      SELF_ID_RATE_FIELD_OUT <= speed_r;
      PEER_SPEED_ADV_OUT     <= `PVP_SPEED_S400;
      SELF_ID_PWR_OUT        <= pwr_r;
      PORT_DISABLE_OUT       <= dis_r;
    end
  end

endmodule

// ===== rtl/pvp_regs.vh
// Notes on behaviour
// - page select 1 shows identification page
// - compliance byte 01h at paged address 8
// - maker oui bytes at 0xA..0xC, msb first
// - part ident bytes at 0xD..0xF, msb first
// - page select 7 shows vendor control page
// - hold flag set with ARB_ACCEL_IN high keeps requests on null packets
// - hold set with ARB_ACCEL_IN high: only packets over 8 bits clear
// - hold clear: any non-ack packet clears requests
// - hold flag resets 0, survives bus reset
// - link speed rw, code 11 illegal
// - link speed copied into self-id rate field
// - peers always see S400 capability
// - link speed resets to 10b, survives bus reset
// - straps give default self-id power bits 21-23
// - straps load after reset once synchronised, register 4 overrides
// - power class codes, 101 reserved
// - port disable clears on hardware reset only
`ifndef PVP_REGS_VH
`define PVP_REGS_VH

// ----------------------------------------------------------------
// base register map
// ----------------------------------------------------------------
`define PVP_BASE_PWR_REG      4'h4
`define PVP_BASE_PAGE_REG     4'h7
`define PVP_PAGE_SEL_HI       7
`define PVP_PAGE_SEL_LO       5
`define PVP_PORT_SEL_HI       3
`define PVP_PORT_SEL_LO       0
`define PVP_PWR_HI            2
`define PVP_PWR_LO            0

// ----------------------------------------------------------------
// pages and paged offsets
// ----------------------------------------------------------------
`define PVP_PAGE_PORT         3'h0
`define PVP_PAGE_IDENT        3'h1
`define PVP_PAGE_VENDOR       3'h7
`define PVP_OFS_COMPLIANCE    4'h8
`define PVP_OFS_ID_SPARE      4'h9
`define PVP_OFS_OUI_HI        4'hA
`define PVP_OFS_OUI_MID       4'hB
`define PVP_OFS_OUI_LO        4'hC
`define PVP_OFS_PART_HI       4'hD
`define PVP_OFS_PART_MID      4'hE
`define PVP_OFS_PART_LO       4'hF
`define PVP_OFS_VENDOR_CTRL   4'h8
`define PVP_OFS_PORT_CTRL     4'h8

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PVP_HOLD_BIT          7
`define PVP_SPEED_HI          1
`define PVP_SPEED_LO          0
`define PVP_DIS_BIT           0
`define PVP_COMPLIANCE_VAL    8'h01
`define PVP_HOLD_RST          1'h0
`define PVP_SPEED_RST         2'h2
`define PVP_SPEED_ILLEGAL     2'h3
`define PVP_SPEED_S400        2'h2
`define PVP_PWR_RESERVED      3'h5
`define PVP_ACK_BITS          16'h0008
`define PVP_PORTS             2

`endif

// ===== dv/pvp_link_model.sv
`timescale 1ns/1ns
// ----
// received-packet reporter on the far side
// ----
module pvp_link_model (
  // clock
  input  wire logic        clk_in,
  // request from the bench
  input  wire logic        go_in,
  input  wire logic [15:0] bits_in,
  // report towards the block
  output logic             done_out = 1'b0,
  output logic [15:0]      bits_out = 16'h0000
);
  // count only qualifies the done pulse; idle it toggles so stale values never look valid
  always @(posedge clk_in) begin
    done_out <= go_in;
    bits_out <= go_in ? bits_in : ~bits_out;
  end
endmodule

// ===== dv/pvp_monitor.sv
`timescale 1ns/1ns
module pvp_monitor (
  input wire logic        CLOCK_IN,
  input wire logic        RESETN_IN,
  input wire logic [3:0]  ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic        PKT_DONE_IN,
  input wire logic [15:0] PKT_BITS_IN,
  input wire logic        ARB_ACCEL_IN,
  input wire logic        FAIR_REQ_SET_IN,
  input wire logic        PRIO_REQ_SET_IN,
  input wire logic        FAIR_REQ_OUT,
  input wire logic        PRIO_REQ_OUT,
  input wire logic [1:0]  SELF_ID_RATE_FIELD_OUT,
  input wire logic [1:0]  PEER_SPEED_ADV_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  // identification page selected, one idle cycle, then compliance read
  sequence s_sel_ident;
    WR_IN && ADDR_IN == 4'h7 && WDATA_IN[7:5] == 3'h1 ##1 !WR_IN;
  endsequence
  sequence s_rd_compl;
    RD_IN && !WR_IN && ADDR_IN == 4'h8;
  endsequence
  chk_ident_compl: assert property (s_sel_ident ##1 s_rd_compl |=> RDATA_OUT == 8'h01)
    else $error("compliance byte wrong");
  chk_rd_quiet: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  chk_adv_fixed: assert property (PEER_SPEED_ADV_OUT == 2'h2)
    else $error("peer speed not S400");
  chk_speed_legal: assert property (SELF_ID_RATE_FIELD_OUT != 2'h3)
    else $error("illegal rate field");
  chk_set_fair: assert property (FAIR_REQ_SET_IN |-> ##[1:2] FAIR_REQ_OUT)
    else $error("fair request not set");
  chk_nonack_fair: assert property (!ARB_ACCEL_IN && PKT_DONE_IN &&
    PKT_BITS_IN != 16'h0008 && !FAIR_REQ_SET_IN |-> ##[1:2] !FAIR_REQ_OUT)
    else $error("non-ack packet kept fair request");
  chk_long_prio: assert property (PKT_DONE_IN && PKT_BITS_IN > 16'h0008 &&
    !PRIO_REQ_SET_IN |-> ##[1:2] !PRIO_REQ_OUT)
    else $error("long packet kept priority request");
  chk_ack_keeps: assert property (FAIR_REQ_OUT && PKT_DONE_IN &&
    PKT_BITS_IN == 16'h0008 |=> FAIR_REQ_OUT)
    else $error("ack cleared fair request");
endmodule
bind pvp_top pvp_monitor u_mon (.*);

// ===== dv/test_pvp_top.sv
`timescale 1ns/1ns
module test_pvp_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        go = 1'b0;
  logic [15:0] nbits = 16'h0000;
  logic        accel = 1'b1;
  logic        fset = 1'b0;
  logic        pset = 1'b0;
  wire  [7:0]  rdata;
  wire         done;
  wire  [15:0] pbits;
  wire         freq;
  wire         preq;
  wire  [1:0]  rate;
  wire  [1:0]  adv;
  wire  [1:0]  dis;
  wire  [2:0]  pwr;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  // ----
  // clock, block and far side
  // ----
  always #10 clk = ~clk;
  pvp_top uut (.CLOCK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .POWER_CLASS_STRAPS_IN(3'h6),
    .PKT_DONE_IN(done), .PKT_BITS_IN(pbits), .ARB_ACCEL_IN(accel),
    .FAIR_REQ_SET_IN(fset), .PRIO_REQ_SET_IN(pset), .FAIR_REQ_OUT(freq),
    .PRIO_REQ_OUT(preq), .SELF_ID_RATE_FIELD_OUT(rate), .PEER_SPEED_ADV_OUT(adv),
    .SELF_ID_PWR_OUT(pwr), .PORT_DISABLE_OUT(dis));
  pvp_link_model u_link (.clk_in(clk), .go_in(go), .bits_in(nbits), .done_out(done),
    .bits_out(pbits));
  // ----
  // shared tasks
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe dropped with an idle edge so back-to-back calls never assign twice
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string what);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, e, rdata);
    @(posedge clk);
  endtask
  // partner reports a packet; wait covers its edge plus the clearing edge
  task automatic pkt(input logic [15:0] b, input logic [1:0] e);
    nbits <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("requests", {6'h0, e}, {6'h0, freq, preq});
    @(posedge clk);
  endtask
  task automatic setreq();
    fset <= 1'b1;
    pset <= 1'b1;
    @(posedge clk);
    fset <= 1'b0;
    pset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("requests set", 8'h03, {6'h0, freq, preq});
    @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_ident();
    logic [7:0] id [8];
    id = '{8'h01, 8'h00, 8'h12, 8'h34, 8'h56, 8'hAB, 8'hCD, 8'hEF};
    wr_reg(4'h7, 8'h20);
    for (int i = 0; i < 8; i++) rd_chk(4'h8 + i[3:0], id[i], "ident");
    wr_reg(4'hA, 8'h00);
    rd_chk(4'hA, 8'h12, "oui after write");
  endtask
  task automatic t_vendor();
    wr_reg(4'h7, 8'hE0);
    rd_chk(4'h8, 8'h02, "vendor reset");
    wr_reg(4'h8, 8'h81);
    rd_chk(4'h8, 8'h81, "hold and speed");
    chk("rate field", 8'h01, {6'h0, rate});
    wr_reg(4'h8, 8'h03);
    rd_chk(4'h8, 8'h01, "illegal speed");
    rd_chk(4'h9, 8'h00, "test location");
    rd_chk(4'h2, 8'h00, "unmapped");
  endtask
  task automatic t_hold();
    wr_reg(4'h8, 8'h82);
    setreq();
    pkt(16'h0000, 2'h3);
    pkt(16'h0008, 2'h3);
    pkt(16'h0009, 2'h0);
    wr_reg(4'h8, 8'h02);
    accel <= 1'b0;
    setreq();
    pkt(16'h0008, 2'h3);
    pkt(16'h0003, 2'h0);
  endtask
  task automatic t_power();
    wr_reg(4'h4, 8'h05);
    rd_chk(4'h4, 8'h05, "power readback");
    chk("power class", 8'h05, {5'h0, pwr});
    wr_reg(4'h7, 8'h01);
    wr_reg(4'h8, 8'h01);
    rd_chk(4'h8, 8'h01, "port 1 disable");
    chk("disable pins", 8'h02, {6'h0, dis});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("power after reset", 8'h06, {5'h0, pwr});
    chk("disable after reset", 8'h00, {6'h0, dis});
  endtask
  // hang guard sized well above the scenario run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("reset view", 8'hAC, {rate, adv, pwr, |dis});
    @(posedge clk);
    t_ident();
    t_vendor();
    t_hold();
    t_power();
    wrap_up();
  end
endmodule
